/* File: src/serial_config_memory_readout.sv */
// Read-out side of a serial configuration memory, clocked by the FPGA.
// Assumes the four control pins are asynchronous to clk_in and synchronised here; the write ports are used unsynchronised.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] Serial data pin presents one stored bit at a time to the FPGA.
// [R02] Read position advances only on rising edges of the FPGA clock.
// [R03] Cascade enable output drives the next memory's chip-select.
// [R04] Programming select stays high while loading; low only to program.
// [R05] Ready pin pulled low during power-on reset, then released.
// [R06] Clock after the last bit drops cascade enable, floats data.
// [R07] Low chip-select on a downstream memory enables its data output.
// [R08] Active reset level clears the address counters after loading.
// [R09] Holding reset inactive keeps counters; no reset after loading.
// [R10] Reset polarity is a stored, user-programmable setting.
// [R11] Low programming select enters programming mode for memory writes.
// [R12] High chip-select puts the device in low-power standby; not in programming mode here.
// [R13] In standby data stays floating regardless of output enable.
// [R14] The FPGA fetches its program itself, at power-up or on command.
// [R15] Smallest variant has no cascade output and cannot cascade.
// [R16] Reset level clears both the address and bit counters.
// [R17] Counting and data drive only with chip-select low, enable high.
// [R18] Cascade output stays low, then follows chip-select until reset; here high until the last bit.
// [R19] Power-up clears the address counter before any read.
// [R20] Counter width and terminal count follow the stored capacity.
module serial_config_memory_readout
  import cfg_loader_pkg::*;
#(
  parameter int   DEPTH       = cfg_loader_pkg::DEPTH_BITS,
  parameter int   W           = cfg_loader_pkg::WORD_W,
  parameter logic HAS_CASCADE = 1'b1
)
(
  input  wire logic                        clk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        fpga_config_clock_in,
  input  wire logic                        chip_select_n_in,
  input  wire logic                        reset_oe_in,
  input  wire logic                        program_mode_select_n_in,
  input  wire logic                        mem_wr_en_in,
  input  wire logic [$clog2(DEPTH/W)-1:0]  mem_wr_addr_in,
  input  wire logic [W-1:0]                mem_wr_data_in,
  input  wire logic                        polarity_wr_en_in,
  input  wire logic                        polarity_val_in,
  output logic                             config_data_out,
  output logic                             config_data_oe_out,
  output logic                             cascade_enable_out_n,
  output logic                             ready_out,
  output logic                             ready_oe_out,
  output logic                             standby_out,
  output logic                             in_system_programming_out
);
  import cfg_loader_pkg::*;

  localparam int AW    = $clog2(DEPTH);
  localparam int WORDS = DEPTH / W;
  localparam int WAW   = $clog2(WORDS);
  localparam int IW    = $clog2(W);
  localparam logic [AW-1:0]  LAST_BIT  = AW'(DEPTH - 1);
  localparam logic [WAW-1:0] LAST_WORD = WAW'(WORDS - 1);
  localparam logic [IW-1:0]  LAST_IDX  = IW'(W - 1);

  logic [PIN_N-1:0] sync1_r;
  logic [PIN_N-1:0] sync2_r;
  logic             clk_d_r;
  logic [W-1:0]     mem [WORDS];
  logic             polarity_r;
  logic [POR_W-1:0] por_cnt_r;
  logic             por_busy_r;
  logic [AW-1:0]    bit_addr_r;
  logic [WAW-1:0]   word_addr_r;
  logic             fetch_done_r;
  logic [W-1:0]     cur_word_r;
  logic             cur_valid_r;
  logic [IW-1:0]    bit_idx_r;
  logic             done_r;
  logic             data_r;
  logic             data_oe_r;
  logic             cascade_n_r;
  logic             clk_rise;
  logic             cs_n;
  logic             prog_mode;
  logic             rst_active;
  logic             enable;
  logic             clear;
  logic             advance;
  logic             word_end;

  word_buf_if #(.W(W)) buf_io ();

  word_buffer u_buf (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .buf_io  (buf_io)
  );

  // Two-stage synchronisers on the four control pin inputs (clock, chip-select, reset/OE, programming select)
  generate
    for (genvar i = 0; i < PIN_N; i++)
    begin : g_sync
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          sync1_r[i] <= SYNC_INIT[i];
          sync2_r[i] <= SYNC_INIT[i];
        end
        else
        begin
          sync1_r[i] <= (i == PIN_CLK)    ? fpga_config_clock_in :
                        (i == PIN_CS_N)   ? chip_select_n_in :
                        (i == PIN_RST_OE) ? reset_oe_in :
                                            program_mode_select_n_in;
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      clk_d_r <= 1'b0;
    end
    else
    begin
      clk_d_r <= sync2_r[PIN_CLK];
    end
  end

  assign clk_rise   = sync2_r[PIN_CLK] && !clk_d_r; // [R02]
  assign cs_n       = sync2_r[PIN_CS_N];
  assign prog_mode  = !sync2_r[PIN_PROG_N]; // [R11] [R04]
  assign rst_active = polarity_r ? sync2_r[PIN_RST_OE]
                                 : !sync2_r[PIN_RST_OE]; // [R10]
  assign enable     = !cs_n && !rst_active && !prog_mode; // [R17] [R07]
  assign clear      = rst_active || prog_mode || por_busy_r; // [R16] [R08]
  assign advance    = clk_rise && enable && cur_valid_r && !done_r;
  assign word_end   = (bit_idx_r == LAST_IDX);

  // Power-on reset cycle drives the ready pin low
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      por_cnt_r  <= '0;
      por_busy_r <= 1'b1;
    end
    else if (por_busy_r)
    begin
      por_cnt_r  <= por_cnt_r + POR_W'(1);
      por_busy_r <= (por_cnt_r != POR_W'(POR_CYCLES - 1)); // [R05]
    end
  end

  // Memory and polarity are only written in programming mode
  always_ff @(posedge clk_in)
  begin
    if (prog_mode && mem_wr_en_in)
    begin
      mem[mem_wr_addr_in] <= mem_wr_data_in; // [R11]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      polarity_r <= RESET_POL_DFLT;
    end
    else if (prog_mode && polarity_wr_en_in)
    begin
      polarity_r <= polarity_val_in; // [R10]
    end
  end

  // Word fetch into the buffer; stalls while the buffer is full
  assign buf_io.flush     = clear;
  assign buf_io.in_valid  = !fetch_done_r;
  assign buf_io.in_data   = mem[word_addr_r];
  assign buf_io.out_ready = !cur_valid_r || (advance && word_end);

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      word_addr_r  <= '0; // [R19]
      fetch_done_r <= 1'b0;
    end
    else if (clear)
    begin
      word_addr_r  <= '0; // [R08]
      fetch_done_r <= 1'b0;
    end
    else if (buf_io.in_valid && buf_io.in_ready)
    begin
      word_addr_r  <= word_addr_r + WAW'(1);
      fetch_done_r <= (word_addr_r == LAST_WORD); // [R20]
    end
  end

  // Bit serialiser, address counter and end-of-data flag
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bit_addr_r  <= '0; // [R19]
      bit_idx_r   <= '0;
      cur_word_r  <= '0;
      cur_valid_r <= 1'b0;
      done_r      <= 1'b0;
    end
    else if (clear)
    begin
      bit_addr_r  <= '0; // [R16]
      bit_idx_r   <= '0;
      cur_valid_r <= 1'b0;
      done_r      <= 1'b0;
    end
    else
    begin
      if (advance)
      begin
        bit_addr_r <= bit_addr_r + AW'(1); // [R17]
        bit_idx_r  <= bit_idx_r + IW'(1);
        if (bit_addr_r == LAST_BIT)
        begin
          done_r <= 1'b1; // [R06] [R20]
        end
      end
      if (buf_io.out_ready)
      begin
        cur_valid_r <= buf_io.out_valid;
        cur_word_r  <= buf_io.out_data;
      end
    end
  end

  // Data pin: MSB first, floats in standby, reset or after the last bit
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      data_r    <= 1'b0;
      data_oe_r <= 1'b0;
    end
    else
    begin
      data_r    <= cur_word_r[LAST_IDX - bit_idx_r]; // [R01]
      // Drive only once a fetched word stands, so no stale bit shows
      data_oe_r <= enable && !done_r && !clear && cur_valid_r; // [R06] [R13] [R17]
    end
  end

  // Cascade output low after the end, then follows chip-select
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cascade_n_r <= 1'b1;
    end
    else
    begin
      cascade_n_r <= !HAS_CASCADE || !done_r || clear || cs_n; // [R18] [R03] [R15]
    end
  end

  assign config_data_out           = data_r;
  assign config_data_oe_out        = data_oe_r;
  assign cascade_enable_out_n      = cascade_n_r;
  assign ready_out                 = 1'b0;
  assign ready_oe_out              = por_busy_r; // [R05]
  assign standby_out               = cs_n && !prog_mode; // [R12]
  assign in_system_programming_out = prog_mode;
endmodule
`default_nettype wire

/* File: include/cfg_loader_pkg.sv */
// Constants shared by the serial configuration read-out logic.
// Assumes a single 100 MHz system clock samples every pin.
package cfg_loader_pkg;
  localparam int          CLK_FREQ_MHZ   = 100;
  localparam int          WORD_W         = 8;
  localparam int          DEPTH_BITS     = 65536;
  localparam int          BUF_DEPTH      = 2;
  localparam int          POR_TIME_NS    = 1000;
  localparam int          POR_CYCLES     = (POR_TIME_NS * CLK_FREQ_MHZ
                                            + 999) / 1000;
  localparam int          POR_W          = 8;
  localparam logic        RESET_POL_DFLT = 1'b0;
  localparam int          PIN_CLK        = 0;
  localparam int          PIN_CS_N       = 1;
  localparam int          PIN_RST_OE     = 2;
  localparam int          PIN_PROG_N     = 3;
  localparam int          PIN_N          = 4;
  localparam logic [3:0]  SYNC_INIT      = 4'he;
endpackage

/* File: include/word_buf_if.sv */
// Carrier between the read-out logic and its two-entry word buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface word_buf_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  logic         flush;
  modport store (input in_valid, in_data, out_ready, flush,
                 output in_ready, out_valid, out_data);
  modport user  (output in_valid, in_data, out_ready, flush,
                 input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* File: src/word_buffer.sv */
// Two-entry word buffer with valid/ready on both sides and a flush.
// Assumes the user side drives the interface from the same clock.
`timescale 1ns/1ps
`default_nettype none
module word_buffer
  import cfg_loader_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     nrst_in,
  word_buf_if.store     buf_io
);
  logic [1:0]          count_r;
  logic [WORD_W-1:0]   head_r;
  logic [WORD_W-1:0]   tail_r;
  logic                push;
  logic                pop;

  assign buf_io.in_ready  = (count_r != 2'(BUF_DEPTH)) && !buf_io.flush;
  assign buf_io.out_valid = (count_r != 2'h0) && !buf_io.flush;
  assign buf_io.out_data  = head_r;
  assign push = buf_io.in_valid && buf_io.in_ready;
  assign pop  = buf_io.out_valid && buf_io.out_ready;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      count_r <= 2'h0;
    end
    else if (buf_io.flush)
    begin
      count_r <= 2'h0;
    end
    else if (push && !pop)
    begin
      count_r <= count_r + 2'h1;
    end
    else if (pop && !push)
    begin
      count_r <= count_r - 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      head_r <= '0;
      tail_r <= '0;
    end
    else
    begin
      if (pop)
      begin
        head_r <= (count_r == 2'h2) ? tail_r : buf_io.in_data;
      end
      else if (push && count_r == 2'h0)
      begin
        head_r <= buf_io.in_data;
      end
      if (push && (count_r == 2'h2 || (count_r == 2'h1 && !pop)))
      begin
        tail_r <= buf_io.in_data;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/readout_sva.sv */
// Checker on the pins of the serial read-out block.
// Assumes it is bound onto the top module with the same parameters.
`timescale 1ns/1ps
`default_nettype none
module readout_sva
#(
  parameter int DEPTH = 64,
  parameter int W     = 8
)
(
  input wire logic                       clk_in,
  input wire logic                       nrst_in,
  input wire logic                       fpga_config_clock_in,
  input wire logic                       chip_select_n_in,
  input wire logic                       reset_oe_in,
  input wire logic                       program_mode_select_n_in,
  input wire logic                       mem_wr_en_in,
  input wire logic [$clog2(DEPTH/W)-1:0] mem_wr_addr_in,
  input wire logic [W-1:0]               mem_wr_data_in,
  input wire logic                       polarity_wr_en_in,
  input wire logic                       polarity_val_in,
  input wire logic                       config_data_out,
  input wire logic                       config_data_oe_out,
  input wire logic                       cascade_enable_out_n,
  input wire logic                       ready_out,
  input wire logic                       ready_oe_out,
  input wire logic                       standby_out,
  input wire logic                       in_system_programming_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence idle_s;
    (chip_select_n_in && program_mode_select_n_in)[*4];
  endsequence
  sequence deselect_s;
    chip_select_n_in[*5];
  endsequence
  ready_level_a: assert property (ready_out == 1'b0)
    else $error("ready pin driven high");
  por_hold_a: assert property ($rose(nrst_in) |-> ready_oe_out[*8])
    else $error("ready released too early");
  standby_entry_a: assert property (idle_s |-> standby_out)
    else $error("no standby while deselected");
  standby_float_a: assert property (deselect_s |-> !config_data_oe_out)
    else $error("data driven in standby");
  prog_mode_a: assert property ((!program_mode_select_n_in)[*4]
    |-> in_system_programming_out && !config_data_oe_out)
    else $error("programming mode not entered");
  drive_cause_a: assert property ($rose(config_data_oe_out)
    |-> $past(!chip_select_n_in, 3))
    else $error("data driven without select");
  bit_step_a: assert property ($changed(config_data_out)
    && config_data_oe_out && $past(config_data_oe_out)
    |-> $past(fpga_config_clock_in, 3))
    else $error("bit moved without clock");
  end_float_a: assert property ($fell(cascade_enable_out_n)
    |-> !config_data_oe_out)
    else $error("data driven with cascade low");
  reset_cascade_a: assert property ((!reset_oe_in)[*5]
    |-> cascade_enable_out_n)
    else $error("cascade low during reset");
endmodule
`default_nettype wire

/* File: testbench/fpga_master_model.sv */
// Behavioural master-serial loader: clocks bits out and shifts them in.
// Assumes one clk_in; the loader clock rests low between bursts.
`timescale 1ns/1ps
`default_nettype none
module fpga_master_model
(
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [7:0]  n_in,
  input  wire logic        data_in,
  input  wire logic        data_oe_in,
  output logic             fclk_out,
  output logic             busy_out,
  output logic [63:0]      bits_out
);
  logic last_r;
  logic pin;
  // Released line shows the inverse of its last level
  assign pin = data_oe_in ? data_in : ~last_r;
  initial
  begin
    fclk_out = 1'b0;
    busy_out = 1'b0;
    bits_out = '0;
    last_r   = 1'b0;
  end
  always @(posedge clk_in)
    if (data_oe_in)
      last_r <= data_in;
  always
  begin
    @(posedge go_in);
    busy_out = 1'b1;
    repeat (n_in)
    begin
      repeat (4) @(posedge clk_in);
      #1 bits_out = {bits_out[62:0], pin};
      fclk_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 fclk_out = 1'b0;
    end
    busy_out = 1'b0;
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial read-out block.
// Assumes the loader model sits on the data and clock pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DEPTH = 64;
  localparam int W     = 8;
  logic clk_in = 1'b0, nrst_in = 1'b0, fpga_config_clock_in;
  logic chip_select_n_in = 1'b1, reset_oe_in = 1'b1;
  logic program_mode_select_n_in = 1'b1, mem_wr_en_in = 1'b0;
  logic [2:0] mem_wr_addr_in = 3'h0;
  logic [7:0] mem_wr_data_in = 8'h00, n_bits = 8'h00;
  logic polarity_wr_en_in = 1'b0, polarity_val_in = 1'b0, go = 1'b0;
  logic config_data_out, config_data_oe_out, cascade_enable_out_n;
  logic ready_out, ready_oe_out, standby_out, in_system_programming_out;
  logic busy;
  logic [63:0] bits;
  int bad_count = 0, n_checks = 0;
  logic [7:0] rows [8] = '{8'ha5, 8'h3c, 8'h01, 8'h80,
                           8'hff, 8'h00, 8'h5a, 8'hc3};
  always #5 clk_in = ~clk_in;
  serial_config_memory_readout #(.DEPTH(DEPTH), .W(W))
    u_serial_config_memory_readout (.*);
  fpga_master_model u_fpga_master_model (.clk_in(clk_in), .go_in(go),
    .n_in(n_bits), .data_in(config_data_out),
    .data_oe_in(config_data_oe_out), .fclk_out(fpga_config_clock_in),
    .busy_out(busy), .bits_out(bits));
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic run(input int n);
    n_bits = n[7:0];
    go = 1'b1;
    tick(1);
    go = 1'b0;
    for (int i = 0; i < 999 && busy === 1'b1; i++) tick(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #500000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    tick(6);
    nrst_in = 1'b1;
    tick(1);
    chk("ready_oe", 8'h1, ready_oe_out);
    for (int i = 0; i < 300 && ready_oe_out === 1'b1; i++) tick(1);
    chk("ready_oe", 8'h0, ready_oe_out);
    program_mode_select_n_in = 1'b0;
    tick(4);
    chk("isp", 8'h1, in_system_programming_out);
    for (int i = 0; i < 8; i++)
    begin
      mem_wr_en_in = 1'b1;
      mem_wr_addr_in = i[2:0];
      mem_wr_data_in = rows[i];
      tick(1);
    end
    mem_wr_en_in = 1'b0;
    program_mode_select_n_in = 1'b1;
    tick(6);
    chk("standby", 8'h1, standby_out);
    chk("data_oe", 8'h0, config_data_oe_out);
    chip_select_n_in = 1'b0;
    tick(6);
    chk("standby", 8'h0, standby_out);
    chk("data_oe", 8'h1, config_data_oe_out);
    run(64);
    tick(4);
    for (int i = 0; i < 8; i++)
      chk("word", rows[i], bits[63-8*i -: 8]);
    chk("cascade", 8'h0, cascade_enable_out_n);
    chk("data_oe", 8'h0, config_data_oe_out);
    chip_select_n_in = 1'b1;
    tick(6);
    chk("cascade", 8'h1, cascade_enable_out_n);
    chip_select_n_in = 1'b0;
    tick(6);
    chk("cascade", 8'h0, cascade_enable_out_n);
    reset_oe_in = 1'b0;
    tick(6);
    chk("cascade", 8'h1, cascade_enable_out_n);
    chk("data_oe", 8'h0, config_data_oe_out);
    reset_oe_in = 1'b1;
    tick(6);
    run(8);
    chk("reread", rows[0], bits[7:0]);
    chk("cascade", 8'h1, cascade_enable_out_n);
    program_mode_select_n_in = 1'b0;
    tick(3);
    polarity_val_in = 1'b1;
    polarity_wr_en_in = 1'b1;
    tick(1);
    polarity_wr_en_in = 1'b0;
    program_mode_select_n_in = 1'b1;
    tick(6);
    chk("data_oe", 8'h0, config_data_oe_out);
    reset_oe_in = 1'b0;
    tick(6);
    chk("data_oe", 8'h1, config_data_oe_out);
    end_of_test();
  end
endmodule
bind serial_config_memory_readout readout_sva #(.DEPTH(DEPTH), .W(W))
  u_readout_sva (.*);
`default_nettype wire
